// ==== common/gpw_pkg.sv ====
// Package holding constants and types for the four-level page walker.
package gpw_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PA_W        = 46;  // Widest host address
    localparam int VA_W        = 48;  // Virtual address width
    localparam int HAW_CLIENT  = 39;  // Host address width, client build
    localparam int HAW_SERVER  = 46;  // Host address width, server build
    localparam int CACHE_DEPTH = 512; // Entries in a 4KB table store
    localparam int SMALL_DEPTH = 8;   // Second-level cache, 8 direct-mapped slots
    localparam int TAG_W       = PA_W - 3;

    // ------------------------------------------------------------
    // Engine kinds
    // ------------------------------------------------------------
    localparam int ENG_3D     = 0;
    localparam int ENG_MEDIA  = 1;
    localparam int ENG_VIDEO  = 2;    // video_enhance_engine
    localparam int ENG_BLIT   = 3;

    // ------------------------------------------------------------
    // Leaf entry fields
    // ------------------------------------------------------------
    localparam int BIT_PRESENT = 0;
    localparam int BIT_WRITE   = 1;
    localparam int BIT_WT      = 3;   // write_through_bit
    localparam int BIT_CD      = 4;   // cache_disable_bit
    localparam int BIT_ATTR    = 7;   // attribute_index_bit, page size in PDE
    localparam int BIT_NULL    = 9;
    localparam int FRAME_LSB   = 12;
    localparam int BIG_LSB     = 21;  // 2MB frame base

    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ROOT_LO = 8'h04;
    localparam logic [7:0] OFS_ROOT_HI = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_COUNT   = 8'h10;
    localparam int CTRL_SERVER   = 0;
    localparam int CTRL_ADVANCED = 1;
    localparam int CTRL_COHERENT = 2;
    localparam int CTRL_FLUSH    = 3;
    localparam logic [3:0] CTRL_RESET = 4'h2;

    // ------------------------------------------------------------
    // Walk states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {GPW_IDLE, GPW_LOOK, GPW_WAIT, GPW_DONE} gpw_state_t;

endpackage

// ==== logic/gpw_walker.sv ====
// Four-level page walker with upper-level entry caches and leaf decode.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// ------------------------------------------------------------
// Notes on behaviour
// - Leaf ignored bits never affect the result
// - Output address is frame base plus offset
// - Nested context marks result as guest physical
// - Null page read: no access, zero data
// - Null page write is silently dropped
// - Memory type from attribute, disable, write-through
// - Write bit clear refuses user, protected supervisor
// - Supervisor writes checked only through the write protect flag
// - Leaf valid only when present bit set
// - Address width 39 client, 46 server
// - Advanced mode walks four table levels
// - Walk starts at context top-level pointer
// - 3D: top store, third cache, 8-slot second cache
// - Media engine: same structures as 3D
// - Video and blitter share one 4KB cache
// - Shared cache split into level regions
// - 2MB page: second-level entry is final
// - Legacy contexts take pointer from software register
// ------------------------------------------------------------
module gpw_walker
    import gpw_pkg::*;
#(
    parameter int ENGINE = ENG_3D               // Engine this walker serves
)(
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // Process context entry
    input  wire logic [PA_W-1:0]   ctx_root,
    input  wire logic              ctx_nested,
    input  wire logic              ctx_wpe,
    // Client request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [VA_W-1:0]   req_va,
    input  wire logic              req_write,
    input  wire logic              req_super,
    // Client answer
    output logic                   rsp_valid,
    output logic      [PA_W-1:0]   rsp_addr,
    output logic                   rsp_fault,
    output logic                   rsp_denied,
    output logic                   rsp_null,
    output logic                   rsp_dropped,
    output logic                   rsp_guest,
    output logic      [2:0]        rsp_mem_type,
    output logic      [63:0]       rsp_data,
    // Table memory read port
    output logic                   mem_valid,
    input  wire logic              mem_ready,
    output logic      [PA_W-1:0]   mem_addr,
    input  wire logic              mem_rvalid,
    input  wire logic [63:0]       mem_rdata
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam bit SHARED = (ENGINE == ENG_VIDEO) || (ENGINE == ENG_BLIT);
    localparam int C_DEPTH = 2 * CACHE_DEPTH + SMALL_DEPTH; // All entry stores together

    logic [3:0]        ctrl;                    // Control register
    logic [PA_W-1:0]   legacy_root;             // Software table pointer
    logic [15:0]       walk_cnt;                // Completed walks
    logic [15:0]       fault_cnt;               // Walks ended by fault
    gpw_state_t        st;                      // Walk state
    logic [1:0]        lvl;                     // Level being fetched
    logic [PA_W-1:0]   base;                    // Table base of this level
    logic [VA_W-1:0]   va;                      // Held virtual address
    logic              wr;                      // Held write flag
    logic              sup;                     // Held supervisor flag
    logic              nested;                  // Held nested flag
    logic              supervisor_write_protect_enable;                     // Held write protect flag
    logic [8:0]        vidx;                    // Index slice for level
    logic [PA_W-1:0]   ent_addr;                // Address of entry
    logic [PA_W-1:0]   haw_mask;                // Host address mask
    logic [63:0]       ent;                     // Entry in use this cycle
    logic              hit;                     // Entry found in cache
    logic              cacheable;               // Level is cached
    logic              step;                    // Entry in hand this cycle
    logic [10:0]       cidx;                    // Slot in the entry store
    logic              leaf;                    // Entry ends the walk
    logic              ent_ok;                  // Entry valid for use
    // Regions: top 0-511, third 512-1023, second 1024-1031; shared uses the first
    logic [63:0]       tbl [C_DEPTH];           // Cached table entries
    logic [TAG_W-1:0]  tag [C_DEPTH];           // Entry address held in each slot
    logic [C_DEPTH-1:0] val;                    // Slot holds a present entry
    // ------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------
    // Width select of frame fields
    assign haw_mask = ctrl[CTRL_SERVER] ? {PA_W{1'b1}}
                    : {{(PA_W-HAW_CLIENT){1'b0}}, {HAW_CLIENT{1'b1}}};

    // Index slice per level: nine bits each, top level first
    assign vidx = va[(VA_W - 9) - 9 * lvl +: 9];
    // Entry address in the current table
    assign ent_addr = {base[PA_W-1:FRAME_LSB], vidx, 3'b000} & haw_mask;
    // Cache placement per level; the leaf level is never cached
    always_comb
    begin
        cacheable = (lvl != 2'd3);
        cidx      = {2'b00, ent_addr[11:3]};
        if (SHARED)
        begin
            // One 4KB store, split in 128-entry level regions
            cidx = {2'b00, lvl, ent_addr[9:3]};
        end
        else if (lvl == 2'd1)
        begin
            cidx = {2'b01, ent_addr[11:3]};
        end
        else if (lvl == 2'd2)
        begin
            cidx = {2'b10, 6'h00, ent_addr[5:3]};
        end
    end
    // Hit check and entry source
    assign hit = cacheable && val[cidx] && (tag[cidx] == ent_addr[PA_W-1:3]);
    assign ent = hit ? tbl[cidx] : mem_rdata;
    // Entry classification
    assign ent_ok = ent[BIT_PRESENT];
    assign leaf   = (lvl == 2'd3) || (lvl == 2'd2 && ent[BIT_ATTR]);
    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Control and legacy pointer writes; flush bit self-clears
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl        <= CTRL_RESET;
            legacy_root <= '0;
        end
        else
        begin
            ctrl[CTRL_FLUSH] <= 1'b0;
            if (reg_wr)
            begin
                case (reg_addr)
                    OFS_CTRL:    ctrl <= reg_wdata[3:0];
                    OFS_ROOT_LO: legacy_root[31:FRAME_LSB] <= reg_wdata[31:FRAME_LSB];
                    OFS_ROOT_HI: legacy_root[PA_W-1:32] <= reg_wdata[PA_W-33:0];
                    default:     ;
                endcase
            end
        end
    end
    // Read data, valid the cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_CTRL:    reg_rdata <= {28'h0000000, ctrl};
                OFS_ROOT_LO: reg_rdata <= {legacy_root[31:FRAME_LSB], 12'h000};
                OFS_ROOT_HI: reg_rdata <= {18'h00000, legacy_root[PA_W-1:32]};
                OFS_STATUS:  reg_rdata <= {28'h0000000, lvl, st};
                OFS_COUNT:   reg_rdata <= {fault_cnt, walk_cnt};
                default:     reg_rdata <= '0;
            endcase
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // Walk sequencer
    // ------------------------------------------------------------
    assign req_ready = (st == GPW_IDLE);
    assign mem_addr  = ent_addr;
    assign mem_valid = (st == GPW_LOOK) && !hit;
    // Entry in hand: a cache hit while looking, or the memory answer
    assign step      = (st == GPW_LOOK && hit) || (st == GPW_WAIT && mem_rvalid);
    // Level stepping through the four tables
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st     <= GPW_IDLE;
            lvl    <= 2'd0;
            base   <= '0;
            va     <= '0;
            wr     <= 1'b0;
            sup    <= 1'b0;
            nested <= 1'b0;
            supervisor_write_protect_enable    <= 1'b0;
        end
        else
        begin
            unique case (st)
                GPW_IDLE:
                begin
                    if (req_valid)
                    begin
                        // Advanced: context pointer; legacy: software pointer
                        base   <= ctrl[CTRL_ADVANCED] ? ctx_root : legacy_root;
                        lvl    <= 2'd0;
                        va     <= req_va;
                        wr     <= req_write;
                        sup    <= req_super;
                        nested <= ctx_nested;
                        supervisor_write_protect_enable    <= ctx_wpe;
                        st     <= GPW_LOOK;
                    end
                end
                GPW_LOOK, GPW_WAIT:
                begin
                    if (step && (!ent_ok || leaf))
                    begin
                        st <= GPW_DONE;
                    end
                    else if (step)
                    begin
                        // Upper entry present: descend to the next table
                        base <= {ent[PA_W-1:FRAME_LSB], 12'h000} & haw_mask;
                        lvl  <= lvl + 2'd1;
                        st   <= GPW_LOOK;
                    end
                    else if (st == GPW_LOOK && mem_ready)
                    begin
                        // Memory took the read; wait for its answer
                        st <= GPW_WAIT;
                    end
                end
                GPW_DONE:
                begin
                    st <= GPW_IDLE;
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // Cache fill and flush
    // ------------------------------------------------------------
    // Valid bits: flush clears all; a fill in that same cycle still lands
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            val <= '0;
        end
        else
        begin
            if (ctrl[CTRL_FLUSH])
            begin
                val <= '0;
            end
            if (st == GPW_WAIT && mem_rvalid && cacheable && ent_ok)
            begin
                val[cidx] <= 1'b1;
            end
        end
    end
    // Entry and tag storage, no reset
    always_ff @(posedge clk)
    begin
        if (st == GPW_WAIT && mem_rvalid && cacheable)
        begin
            tbl[cidx] <= mem_rdata;
            tag[cidx] <= ent_addr[PA_W-1:3];
        end
    end
    // ------------------------------------------------------------
    // Leaf decode and answer
    // ------------------------------------------------------------
    // Final entry decoded; only used fields are looked at
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rsp_valid    <= 1'b0;
            rsp_addr     <= '0;
            rsp_fault    <= 1'b0;
            rsp_denied   <= 1'b0;
            rsp_null     <= 1'b0;
            rsp_dropped  <= 1'b0;
            rsp_guest    <= 1'b0;
            rsp_mem_type <= 3'h0;
            rsp_data     <= '0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (step && (!ent_ok || leaf))
            begin
                rsp_valid   <= 1'b1;
                rsp_fault   <= !ent_ok;
                rsp_null    <= ent_ok && ent[BIT_NULL] && !wr;
                rsp_dropped <= ent_ok && ent[BIT_NULL] && wr;
                // No supervisor path other than the protect qualifier
                rsp_denied  <= ent_ok && !ent[BIT_NULL] && wr && !ent[BIT_WRITE]
                               && (!sup || supervisor_write_protect_enable);
                rsp_guest   <= ent_ok && nested;
                rsp_data    <= '0;
                rsp_mem_type <= ctrl[CTRL_COHERENT]
                              ? {ent[BIT_ATTR], ent[BIT_CD], ent[BIT_WT]}
                              : 3'h0;
                // Frame from the used field only; other bits masked away
                rsp_addr <= (!ent_ok || ent[BIT_NULL]) ? '0
                          : (lvl == 2'd2) ? {ent[PA_W-1:BIG_LSB], va[20:0]} & haw_mask
                          : {ent[PA_W-1:FRAME_LSB], va[11:0]} & haw_mask;
            end
        end
    end
    // Walk and fault counters
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            walk_cnt  <= '0;
            fault_cnt <= '0;
        end
        else if (rsp_valid)
        begin
            walk_cnt  <= walk_cnt + 16'h0001;
            fault_cnt <= fault_cnt + {15'h0000, rsp_fault};
        end
    end

endmodule

// ==== dv/gpw_table_mem.sv ====
// Table memory model answering the walker's entry reads.
`timescale 1ns/10ps
module gpw_table_mem
    import gpw_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            slow,
    input  wire logic            mem_valid,
    output logic                 mem_ready,
    input  wire logic [PA_W-1:0] mem_addr,
    output logic                 mem_rvalid,
    output logic      [63:0]     mem_rdata
);
    logic [63:0]     tbl [logic [PA_W-1:0]]; // Entries by byte address
    logic [PA_W-1:0] held;                   // Address of the read in flight
    logic            busy;                   // One read outstanding
    int              gap;                    // Wait before ready or data
    int              reads;                  // Reads accepted so far
    // Accept, delay and answer one read; data lines scramble when idle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_ready  <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 64'h0;
            busy       <= 1'b0;
            gap        <= 0;
            reads      <= 0;
        end
        else
        begin
            mem_ready  <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            if (mem_valid && mem_ready)
            begin
                busy  <= 1'b1;
                held  <= mem_addr;
                gap   <= slow ? 3 : 0;
                reads <= reads + 1;
            end
            else if (mem_valid && !busy)
            begin
                gap       <= gap + 1;
                mem_ready <= !slow || gap >= 2;
            end
            // Absent entries read as zero, so a bad index faults
            if (busy && gap == 0)
            begin
                mem_rvalid <= 1'b1;
                mem_rdata  <= tbl.exists(held) ? tbl[held] : 64'h0;
                busy       <= 1'b0;
            end
            else if (busy)
                gap <= gap - 1;
        end
    end
endmodule

// ==== dv/gpw_walker_monitor.sv ====
// Checker of the page walker's port behaviour.
`timescale 1ns/10ps
module gpw_walker_monitor
    import gpw_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst,
    input wire logic            req_valid,
    input wire logic            req_ready,
    input wire logic            rsp_valid,
    input wire logic [PA_W-1:0] rsp_addr,
    input wire logic            rsp_fault,
    input wire logic            rsp_denied,
    input wire logic            rsp_null,
    input wire logic            rsp_dropped,
    input wire logic            rsp_guest,
    input wire logic [63:0]     rsp_data,
    input wire logic            mem_valid,
    input wire logic            mem_ready,
    input wire logic [PA_W-1:0] mem_addr
);
    // ----------------------------------------
    // Answer and memory port relations
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_zero_data: assert property (rsp_valid |-> rsp_data == 64'h0)
        else $error("answer data not zero");
    chk_null_addr: assert property (rsp_valid && rsp_null |-> rsp_addr == 46'h0)
        else $error("null answer carries an address");
    chk_one_outcome: assert property (rsp_valid |->
        $onehot0({rsp_fault, rsp_denied, rsp_null, rsp_dropped})) else $error("outcomes overlap");
    chk_fault_guest: assert property (rsp_valid && rsp_fault |-> !rsp_guest)
        else $error("guest flag on a fault");
    chk_fault_addr: assert property (rsp_valid && rsp_fault |-> rsp_addr == 46'h0)
        else $error("fault carries an address");
    chk_take_busy: assert property (req_valid && req_ready |=> !req_ready [*2])
        else $error("ready too soon after take");
    chk_answer_time: assert property (req_valid && req_ready |-> ##[2:300] rsp_valid)
        else $error("walk never answered");
    chk_ready_after: assert property (rsp_valid |-> !req_ready ##1 req_ready)
        else $error("ready not back after answer");
    chk_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
        else $error("table read dropped or moved");
    chk_mem_align: assert property (mem_valid |-> mem_addr[2:0] == 3'h0 && !req_ready)
        else $error("table read misaligned or idle");
    cover property (rsp_valid && rsp_null);
    cover property (rsp_valid && rsp_fault);
    cover property (rsp_valid && rsp_denied);
endmodule
bind gpw_walker gpw_walker_monitor u_mon (.clk, .rst, .req_valid, .req_ready, .rsp_valid,
    .rsp_addr, .rsp_fault, .rsp_denied, .rsp_null, .rsp_dropped, .rsp_guest, .rsp_data,
    .mem_valid, .mem_ready, .mem_addr);

// ==== dv/gpw_walker_bench.sv ====
// Self-checking bench for the four-level page walker.
`timescale 1ns/10ps
module gpw_walker_bench;
    import gpw_pkg::*;
    // ----------------------------------------
    // Signals, tables and expectations
    // ----------------------------------------
    logic              clk, rst, reg_wr, reg_rd, req_valid, req_write, req_super, slow;
    logic              ctx_nested, ctx_wpe, req_ready, rsp_valid, rsp_fault, rsp_denied;
    logic              rsp_null, rsp_dropped, rsp_guest, mem_valid, mem_ready, mem_rvalid;
    logic [7:0]        reg_addr;
    logic [31:0]       reg_wdata, reg_rdata, rd;
    logic [2:0]        rsp_mem_type, got_m;
    logic [4:0]        got_f;                 // {fault, denied, null, dropped, guest}
    logic [63:0]       rsp_data, mem_rdata, got_d;
    logic [PA_W-1:0]   ctx_root, rsp_addr, mem_addr, got_a;
    logic [VA_W-1:0]   req_va;
    int                fails, comparisons, delta;
    localparam logic [VA_W-1:0] VA  = {9'h1, 9'h2, 9'h3, 9'h4, 12'habc};
    localparam logic [VA_W-1:0] V2M = {9'h1, 9'h2, 9'h5, 9'h4, 12'habc};
    localparam logic [VA_W-1:0] VNP = {9'h7, 39'h0};
    localparam logic [63:0]     FR  = 64'h55_5555_5000;  // Leaf frame base
    localparam logic [3:0] PERM [5] = '{4'h9, 4'hc, 4'hf, 4'hb, 4'h2}; // {wr,sup,wpe,denied}
    gpw_walker #(.ENGINE(ENG_3D)) DUT (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ctx_root,
        .ctx_nested, .ctx_wpe, .req_valid, .req_ready, .req_va, .req_write, .req_super,
        .rsp_valid, .rsp_addr, .rsp_fault, .rsp_denied, .rsp_null, .rsp_dropped,
        .rsp_guest, .rsp_mem_type, .rsp_data, .mem_valid, .mem_ready, .mem_addr,
        .mem_rvalid, .mem_rdata);
    gpw_table_mem mem (.clk, .rst, .slow, .mem_valid, .mem_ready, .mem_addr,
        .mem_rvalid, .mem_rdata);
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rd = reg_rdata;
    endtask
    // One translation; counts table reads it caused
    task automatic go(input logic [VA_W-1:0] va, input logic wr, sp, ns, wp);
        int k;
        delta = mem.reads;
        @(posedge clk);
        req_va     <= va;
        req_write  <= wr;
        req_super  <= sp;
        ctx_nested <= ns;
        ctx_wpe    <= wp;
        req_valid  <= 1'b1;
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 50);
        if (k >= 50)
            k = 400;
        @(posedge clk);
        req_valid <= 1'b0;
        do
        begin
            @(negedge clk);
            k++;
        end while (rsp_valid !== 1'b1 && k < 400);
        if (k >= 400)
        begin
            fails++;
            results();
        end
        got_a = rsp_addr;
        got_f = {rsp_fault, rsp_denied, rsp_null, rsp_dropped, rsp_guest};
        got_m = rsp_mem_type;
        got_d = rsp_data;
        delta = mem.reads - delta;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        {reg_wr, reg_rd, req_valid, req_write, req_super, ctx_nested, ctx_wpe, slow} = 8'h0;
        {reg_addr, reg_wdata, req_va} = 88'h0;
        ctx_root = 46'h1000;
        fails = 0;
        comparisons = 0;
        mem.tbl[46'h1008] = 64'h2001;
        mem.tbl[46'h2010] = 64'h3001;
        mem.tbl[46'h3018] = 64'h4001;
        mem.tbl[46'h3028] = 64'h40_0081;
        mem.tbl[46'h4020] = 64'hffff_ffd5_5555_5d67; // Ignored bits all set
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rreg(OFS_CTRL);
        check(64'(rd), 64'(CTRL_RESET));
        rreg(8'hfc);
        check(64'(rd), 64'h0);
        go(VA, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_a), 64'h55_5555_5abc);
        check(64'(delta), 64'h4);
        go(VA, 1'b1, 1'b0, 1'b0, 1'b0);
        check(64'(got_f), 64'h0);
        check(64'(delta), 64'h1);
        wreg(OFS_CTRL, 32'hb); // Server width, flush caches
        go(VA, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_a), 64'h3fd5_5555_5abc);
        check(64'(delta), 64'h4);
        $display("leaf decode and caching done");
        wreg(OFS_CTRL, 32'h6);
        mem.tbl[46'h4020] = FR | 64'h99;
        go(VA, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_m), 64'h7);
        mem.tbl[46'h4020] = FR | 64'h89;
        go(VA, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_m), 64'h5);
        wreg(OFS_CTRL, 32'h2);
        go(VA, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_m), 64'h0);
        $display("memory type done");
        mem.tbl[46'h4020] = FR | 64'h203;
        go(VA, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_f), 64'h4);
        check(got_d, 64'h0);
        check(64'(got_a), 64'h0);
        go(VA, 1'b1, 1'b0, 1'b0, 1'b0);
        check(64'(got_f), 64'h2);
        $display("null page done");
        mem.tbl[46'h4020] = FR | 64'h1;
        foreach (PERM[i])
        begin
            go(VA, PERM[i][3], PERM[i][2], 1'b0, PERM[i][1]);
            check(64'(got_f), {60'h0, PERM[i][0], 3'h0});
        end
        $display("write permission done");
        @(posedge clk);
        slow <= 1'b1;
        go(VA, 1'b0, 1'b0, 1'b1, 1'b0);
        check(64'({got_f, got_a}), 64'({5'h1, 46'h55_5555_5abc}));
        go(V2M, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'({got_f, got_a}), 64'h40_4abc);
        mem.tbl[46'h4020] = FR | 64'h2;
        go(VA, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_f), 64'h10);
        go(VNP, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_f), 64'h10);
        check(64'(delta), 64'h1);
        $display("nested, large page and faults done");
        mem.tbl[46'h4020] = FR | 64'h1;
        wreg(OFS_ROOT_LO, 32'h1000);
        wreg(OFS_ROOT_HI, 32'h0);
        wreg(OFS_CTRL, 32'h8); // Legacy context, flush caches
        @(posedge clk);
        ctx_root <= 46'h7000;
        go(VA, 1'b0, 1'b0, 1'b0, 1'b0);
        check(64'(got_a), 64'h55_5555_5abc);
        rreg(OFS_ROOT_LO);
        check(64'(rd), 64'h1000);
        rreg(OFS_CTRL);
        check(64'(rd), 64'h0);
        rreg(OFS_COUNT);
        check(64'(rd), 64'h2_0012);
        $display("legacy pointer done");
        results();
    end
endmodule
